// >>> hw/rfc_cfg_regs.sv
// Summary of operation
// - upper nibble of drive-off register sets carrier n-conductance, drivers off
// - lower nibble of drive-off register sets modulation n-conductance, drivers off
// - soft power-down forces each applied conductance nibble msb to one
// - drive-off values apply with drivers off or during load keying, else drive-on values
// - drive-off values are used for target load modulation
// - initiator miller pause lasts width plus one carrier periods, capped
// - target subcarrier low is width mod 8 plus one, high 16 minus
// - bit 7 of phase register takes demodulator clock from field
// - phase field adds carrier cycles to wait before transmission
// - phase delay aligns bits in passive 106k and card emulation
// - bit 7 of receiver register enables level detector amplifier
// - gain field: 18,23,18,23,33,38,43,48 dB
// - receiver low nibble sets level detector sensitivity
// - drive-on register supplies conductance with drivers on, resets 88h
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`include "rfc_defs.svh"
module rfc_cfg_regs #(
   parameter int ADDR_W = 8,
   parameter logic [8:0] HALF_BIT_CLKS = `RFC_HALF_BIT
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // driver state from transmitter control
   input wire logic driver_on,
   input wire logic soft_powerdown,
   input wire logic target_load_keying,
   // conductance to the n-driver
   output rfc_pkg::rfc_nib_t cw_n_conductance_applied,
   output rfc_pkg::rfc_nib_t mod_n_conductance_applied,
   // carrier timing
   input wire logic carrier_tick,
   input wire logic initiator_mode,
   input wire logic pause_req,
   output logic pause_active,
   input wire logic subcarrier_en,
   output logic subcarrier_level,
   input wire logic tx_wait_base_done,
   output logic tx_start,
   // static settings to analog and demodulator
   output logic [7:0] miller_pause_length,
   output logic demod_clock_from_field,
   output logic [6:0] transmit_wait_extension,
   output logic field_detector_amp_on,
   output logic [2:0] receiver_gain_select,
   output rfc_pkg::rfc_db_t receiver_gain_db,
   output rfc_pkg::rfc_nib_t field_detector_sensitivity
);
   import rfc_pkg::*;

   localparam int NREG = 5;
   localparam rfc_byte_t RST [NREG] = '{`RFC_RST_GS_OFF, `RFC_RST_MOD_WIDTH,
      `RFC_RST_TX_PHASE, `RFC_RST_RF_CFG, `RFC_RST_GS_ON};
   localparam logic [5:0] IDX [NREG] = '{`RFC_IDX_GS_OFF, `RFC_IDX_MOD_WIDTH,
      `RFC_IDX_TX_PHASE, `RFC_IDX_RF_CFG, `RFC_IDX_GS_ON};

   // the highest index needs six index bits above the byte lanes
   if (ADDR_W < 8) begin : g_bad_addr
      $error("ADDR_W must be at least 8");
   end
   if (HALF_BIT_CLKS == 9'h000) begin : g_bad_half
      $error("HALF_BIT_CLKS must be at least 1");
   end

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire addr_ok = paddr[1:0] == 2'h0;
   wire wr_acc = psel && penable && pwrite;
   wire rd_setup = psel && !penable && !pwrite;
   logic [NREG-1:0] sel;
   wire any_hit = |sel;
   rfc_byte_t reg_r [NREG];
   rfc_byte_t rd_acc [NREG+1];
   assign rd_acc[0] = 8'h00;

   // one storage word per register, plus its slice of the read mux
   genvar i;
   generate
      for (i = 0; i < NREG; i++) begin : g_reg
         assign sel[i] = addr_ok && paddr[ADDR_W-1:2] == (ADDR_W-2)'(IDX[i]);
         assign rd_acc[i+1] = rd_acc[i] | (sel[i] ? reg_r[i] : 8'h00);
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               reg_r[i] <= RST[i];
            end else if (wr_acc && sel[i]) begin
               reg_r[i] <= pwdata[7:0];
            end
         end
      end
   endgenerate

   wire rfc_byte_t n_driver_conductance_off = reg_r[0];
   wire rfc_byte_t modulation_width_ctrl = reg_r[1];
   wire rfc_byte_t transmit_phase_ctrl = reg_r[2];
   wire rfc_byte_t receiver_rf_config = reg_r[3];
   wire rfc_byte_t n_driver_conductance_on = reg_r[4];

   // zero-wait slave; read data is caught in the setup cycle
   assign pready = psel && penable;
   assign pslverr = psel && penable && !any_hit;

   logic [31:0] prdata_r;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_r <= {24'h00_0000, rd_acc[NREG]};
      end
   end
   assign prdata = prdata_r;

   // ----------------------------------------
   // static fields
   // ----------------------------------------
   assign miller_pause_length = modulation_width_ctrl;
   assign demod_clock_from_field = transmit_phase_ctrl[`RFC_DEMOD_BIT];
   assign transmit_wait_extension = transmit_phase_ctrl[`RFC_TXPH_MSB:0];
   assign field_detector_amp_on = receiver_rf_config[`RFC_AMP_BIT];
   assign receiver_gain_select = receiver_rf_config[`RFC_GAIN_MSB:`RFC_GAIN_LSB];
   assign field_detector_sensitivity = receiver_rf_config[`RFC_LVL_MSB:0];

   // bit 1 of the code is ignored in the lower half of the table
   wire rfc_db_t gain_step = `RFC_GAIN_STEP_DB * {4'h0, receiver_gain_select[1:0]};
   wire rfc_db_t gain_low = receiver_gain_select[0] ? `RFC_GAIN_MID_DB : `RFC_GAIN_LO_DB;
   wire rfc_db_t gain_db_nxt = receiver_gain_select[2] ?
      (`RFC_GAIN_HI_DB + gain_step) : gain_low;
   rfc_db_t gain_db_r;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         gain_db_r <= `RFC_GAIN_HI_DB;
      end else begin
         gain_db_r <= gain_db_nxt;
      end
   end
   assign receiver_gain_db = gain_db_r;

   // ----------------------------------------
   // n-driver conductance
   // ----------------------------------------
   rfc_byte_t gs_applied;
   rfc_gs_apply u_gs_apply (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .gs_off(n_driver_conductance_off),
      .gs_on(n_driver_conductance_on),
      .driver_on(driver_on),
      .soft_powerdown(soft_powerdown),
      .target_load_keying(target_load_keying),
      .gs_applied(gs_applied)
   );
   assign cw_n_conductance_applied = gs_applied[`RFC_CW_MSB:`RFC_CW_LSB];
   assign mod_n_conductance_applied = gs_applied[`RFC_MOD_MSB:`RFC_MOD_LSB];

   // ----------------------------------------
   // miller pause timer, initiator side
   // ----------------------------------------
   // width is latched at start, so a write mid-pause takes effect next pause
   wire [8:0] width_p1 = {1'b0, modulation_width_ctrl} + 9'h001;
   wire [8:0] pause_len = (width_p1 > HALF_BIT_CLKS) ? HALF_BIT_CLKS : width_p1;
   wire pause_start = initiator_mode && pause_req && !pause_active;
   logic pause_active_r;
   logic [8:0] pause_cnt_r;
   wire pause_last = pause_cnt_r == 9'h000;
   wire [8:0] pause_cnt_nxt = pause_start ? (pause_len - 9'h001) :
      (pause_cnt_r - 9'h001);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pause_active_r <= 1'b0;
         pause_cnt_r <= 9'h000;
      end else if (pause_start) begin
         pause_active_r <= 1'b1;
         pause_cnt_r <= pause_cnt_nxt;
      end else if (pause_active_r && carrier_tick) begin
         pause_active_r <= !pause_last;
         pause_cnt_r <= pause_last ? 9'h000 : pause_cnt_nxt;
      end
   end
   assign pause_active = pause_active_r;

   // ----------------------------------------
   // subcarrier duty cycle, target side
   // ----------------------------------------
   wire [3:0] sc_low_len = {1'b0, modulation_width_ctrl[`RFC_SC_LOW_MSB:0]} + 4'h1;
   wire [4:0] sc_high_w = `RFC_SC_PERIOD - {1'b0, sc_low_len};
   wire [3:0] sc_high_len = sc_high_w[3:0];
   rfc_sc_e sc_state_r;
   rfc_sc_e sc_state_nxt;
   logic [3:0] sc_cnt_r;
   logic [3:0] sc_cnt_nxt;
   wire [3:0] sc_phase_len = (sc_state_r == RFC_SC_LOW) ? sc_low_len : sc_high_len;
   wire sc_end = sc_cnt_r == (sc_phase_len - 4'h1);

   // each phase counts carrier ticks, then hands over to the other
   always_comb begin
      sc_state_nxt = sc_state_r;
      sc_cnt_nxt = sc_cnt_r;
      if (!subcarrier_en) begin
         sc_state_nxt = RFC_SC_LOW;
         sc_cnt_nxt = 4'h0;
      end else if (carrier_tick) begin
         sc_cnt_nxt = sc_end ? 4'h0 : sc_cnt_r + 4'h1;
         unique case (sc_state_r)
            RFC_SC_LOW: begin
               if (sc_end) sc_state_nxt = RFC_SC_HIGH;
            end
            RFC_SC_HIGH: begin
               if (sc_end) sc_state_nxt = RFC_SC_LOW;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sc_state_r <= RFC_SC_LOW;
         sc_cnt_r <= 4'h0;
      end else begin
         sc_state_r <= sc_state_nxt;
         sc_cnt_r <= sc_cnt_nxt;
      end
   end
   assign subcarrier_level = sc_state_r == RFC_SC_HIGH;

   // ----------------------------------------
   // transmit wait extension
   // ----------------------------------------
   // a base-done pulse during an extension is ignored, not queued
   rfc_tx_e tx_state_r;
   rfc_tx_e tx_state_nxt;
   logic [6:0] tx_cnt_r;
   logic [6:0] tx_cnt_nxt;
   logic tx_start_r;
   logic tx_start_nxt;

   always_comb begin
      tx_state_nxt = tx_state_r;
      tx_cnt_nxt = tx_cnt_r;
      tx_start_nxt = 1'b0;
      unique case (tx_state_r)
         RFC_TX_IDLE: begin
            if (tx_wait_base_done) begin
               tx_state_nxt = RFC_TX_EXTEND;
               tx_cnt_nxt = transmit_wait_extension;
            end
         end
         RFC_TX_EXTEND: begin
            if (tx_cnt_r == 7'h00) begin
               tx_state_nxt = RFC_TX_IDLE;
               tx_start_nxt = 1'b1;
            end else if (carrier_tick) begin
               tx_cnt_nxt = tx_cnt_r - 7'h01;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_state_r <= RFC_TX_IDLE;
         tx_cnt_r <= 7'h00;
         tx_start_r <= 1'b0;
      end else begin
         tx_state_r <= tx_state_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         tx_start_r <= tx_start_nxt;
      end
   end
   assign tx_start = tx_start_r;

   // ----------------------------------------
   // assertion helpers
   // ----------------------------------------
   logic [8:0] hp_pause_ticks;
   logic [8:0] hp_pause_len;
   logic [3:0] hp_sc_ticks;
   logic [6:0] hp_tx_ticks;
   logic [6:0] hp_tx_len;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         hp_pause_ticks <= 9'h000;
         hp_pause_len <= 9'h000;
         hp_sc_ticks <= 4'h0;
         hp_tx_ticks <= 7'h00;
         hp_tx_len <= 7'h00;
      end else begin
         if (pause_start) begin
            hp_pause_ticks <= 9'h000;
            hp_pause_len <= pause_len;
         end else if (pause_active_r && carrier_tick) begin
            hp_pause_ticks <= hp_pause_ticks + 9'h001;
         end
         if (!subcarrier_en || sc_state_nxt != sc_state_r) begin
            hp_sc_ticks <= 4'h0;
         end else if (carrier_tick) begin
            hp_sc_ticks <= hp_sc_ticks + 4'h1;
         end
         if (tx_state_r == RFC_TX_IDLE && tx_wait_base_done) begin
            hp_tx_ticks <= 7'h00;
            hp_tx_len <= transmit_wait_extension;
         end else if (tx_state_r == RFC_TX_EXTEND && carrier_tick && tx_cnt_r != 7'h00) begin
            hp_tx_ticks <= hp_tx_ticks + 7'h01;
         end
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_cw_off;
      !driver_on && !soft_powerdown |=>
         cw_n_conductance_applied == $past(n_driver_conductance_off[7:4]);
   endproperty
   a_cw_off: assert property (p_cw_off) else $error("cw off value not applied");

   property p_mod_off;
      !driver_on && !soft_powerdown |=>
         mod_n_conductance_applied == $past(n_driver_conductance_off[3:0]);
   endproperty
   a_mod_off: assert property (p_mod_off) else $error("mod off value not applied");

   property p_pdown;
      soft_powerdown |=> cw_n_conductance_applied[3] && mod_n_conductance_applied[3];
   endproperty
   a_pdown: assert property (p_pdown) else $error("power-down msb not forced");

   property p_drv_on;
      driver_on && !target_load_keying && !soft_powerdown |=>
         gs_applied == $past(n_driver_conductance_on);
   endproperty
   a_drv_on: assert property (p_drv_on) else $error("drive-on value not applied");

   property p_load_key;
      target_load_keying && !soft_powerdown |=> gs_applied == $past(n_driver_conductance_off);
   endproperty
   a_load_key: assert property (p_load_key) else $error("load keying value wrong");

   property p_pause;
      $fell(pause_active) |-> hp_pause_ticks == hp_pause_len;
   endproperty
   a_pause: assert property (p_pause) else $error("miller pause length wrong");

   property p_sc_low;
      $rose(subcarrier_level) |-> {1'b0, $past(hp_sc_ticks)} + 5'h01 == {1'b0, $past(sc_low_len)};
   endproperty
   a_sc_low: assert property (p_sc_low) else $error("subcarrier low phase wrong");

   property p_demod;
      wr_acc && sel[2] |=> demod_clock_from_field == $past(pwdata[7]);
   endproperty
   a_demod: assert property (p_demod) else $error("demod clock bit not written");

   property p_tx_wait;
      tx_start |-> hp_tx_ticks == hp_tx_len;
   endproperty
   a_tx_wait: assert property (p_tx_wait) else $error("transmit wait extension wrong");

   property p_tx_zero;
      tx_state_r == RFC_TX_IDLE && tx_wait_base_done && transmit_wait_extension == 7'h00
         |-> ##2 tx_start;
   endproperty
   a_tx_zero: assert property (p_tx_zero) else $error("zero extension start late");

   property p_rf_cfg;
      wr_acc && sel[3] |=> field_detector_amp_on == $past(pwdata[7]) &&
         field_detector_sensitivity == $past(pwdata[3:0]);
   endproperty
   a_rf_cfg: assert property (p_rf_cfg) else $error("receiver config not written");

   property p_gain;
      receiver_gain_select == 3'h3 |=> receiver_gain_db == 6'h17;
   endproperty
   a_gain: assert property (p_gain) else $error("gain code 3 not 23 dB");

   property p_readback;
      rd_setup && sel[0] |=> prdata[7:0] == $past(n_driver_conductance_off);
   endproperty
   a_readback: assert property (p_readback) else $error("readback not stored value");

   c_pause: cover property ($fell(pause_active));
   c_sc: cover property ($rose(subcarrier_level));
   c_tx: cover property (tx_start);
   c_err: cover property (pslverr);
endmodule

// >>> hw/rfc_defs.svh
`ifndef RFC_DEFS_SVH
`define RFC_DEFS_SVH
// ----------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------
`define RFC_IDX_GS_OFF 6'h23
`define RFC_IDX_MOD_WIDTH 6'h24
`define RFC_IDX_TX_PHASE 6'h25
`define RFC_IDX_RF_CFG 6'h26
`define RFC_IDX_GS_ON 6'h27
// ----------------------------------------
// reset values
// ----------------------------------------
`define RFC_RST_GS_OFF 8'h88
`define RFC_RST_MOD_WIDTH 8'h26
`define RFC_RST_TX_PHASE 8'h87
`define RFC_RST_RF_CFG 8'h48
`define RFC_RST_GS_ON 8'h88
// ----------------------------------------
// field positions
// ----------------------------------------
`define RFC_CW_MSB 7
`define RFC_CW_LSB 4
`define RFC_MOD_MSB 3
`define RFC_MOD_LSB 0
`define RFC_DEMOD_BIT 7
`define RFC_TXPH_MSB 6
`define RFC_AMP_BIT 7
`define RFC_GAIN_MSB 6
`define RFC_GAIN_LSB 4
`define RFC_LVL_MSB 3
`define RFC_SC_LOW_MSB 2
// ----------------------------------------
// timing counts in carrier clocks, gain steps in dB
// ----------------------------------------
`define RFC_SC_PERIOD 5'h10
`define RFC_HALF_BIT 9'h040
`define RFC_GAIN_LO_DB 6'h12
`define RFC_GAIN_MID_DB 6'h17
`define RFC_GAIN_HI_DB 6'h21
`define RFC_GAIN_STEP_DB 6'h05
`endif

// >>> hw/rfc_pkg.sv
package rfc_pkg;
   typedef logic [7:0] rfc_byte_t;
   typedef logic [3:0] rfc_nib_t;
   typedef logic [5:0] rfc_db_t;
   typedef enum logic {RFC_SC_LOW, RFC_SC_HIGH} rfc_sc_e;
   typedef enum logic {RFC_TX_IDLE, RFC_TX_EXTEND} rfc_tx_e;
endpackage

// >>> hw/rfc_gs_apply.sv
`timescale 1ns/100ps
`include "rfc_defs.svh"
module rfc_gs_apply (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // stored conductance registers
   input rfc_pkg::rfc_byte_t gs_off,
   input rfc_pkg::rfc_byte_t gs_on,
   // driver state
   input wire logic driver_on,
   input wire logic soft_powerdown,
   input wire logic target_load_keying,
   // value handed to the n-driver, both nibbles
   output rfc_pkg::rfc_byte_t gs_applied
);
   import rfc_pkg::*;

   // ----------------------------------------
   // source selection and power-down forcing
   // ----------------------------------------
   // load keying uses the off set even if a driver is on
   wire use_off = !driver_on || target_load_keying;
   wire rfc_byte_t src = use_off ? gs_off : gs_on;
   // forcing touches only the driven copy, never the stored one
   wire rfc_byte_t pd_mask = {soft_powerdown, 3'h0, soft_powerdown, 3'h0};
   wire rfc_byte_t gs_nxt = src | pd_mask;

   // registered so the analog side never sees decode glitches
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         gs_applied <= `RFC_RST_GS_OFF;
      end else begin
         gs_applied <= gs_nxt;
      end
   end
endmodule

// >>> bench/rfc_cfg_regs_tb.sv
`timescale 1ns/100ps
`include "rfc_defs.svh"
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("mismatch at %0t: %s", $time, msg); end end
module rfc_cfg_regs_tb;
   import rfc_pkg::*;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic driver_on = 1'b0, soft_powerdown = 1'b0, target_load_keying = 1'b0;
   logic carrier_tick = 1'b1, initiator_mode = 1'b0, pause_req = 1'b0;
   logic subcarrier_en = 1'b0, tx_wait_base_done = 1'b0;
   rfc_nib_t cw_app, mod_app, sens;
   rfc_db_t gain_db;
   logic pause_active, subcarrier_level, tx_start, demod_clk, amp_on;
   logic [7:0] pause_len;
   logic [6:0] wait_ext;
   logic [2:0] gain_sel;
   int n_mismatch = 0;
   int check_count = 0;
   logic [31:0] rd;
   logic err;
   int n;
   int h;
   localparam logic [7:0] A_OFF = {`RFC_IDX_GS_OFF, 2'b00};
   localparam logic [7:0] A_WID = {`RFC_IDX_MOD_WIDTH, 2'b00};
   localparam logic [7:0] A_PH = {`RFC_IDX_TX_PHASE, 2'b00};
   localparam logic [7:0] A_RF = {`RFC_IDX_RF_CFG, 2'b00};
   localparam logic [7:0] A_ON = {`RFC_IDX_GS_ON, 2'b00};

   // 100 MHz clock
   always begin
      #5 clk_sys = ~clk_sys;
   end

   rfc_cfg_regs rfc_cfg_regs_i (
      .clk_sys(clk_sys), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .driver_on(driver_on), .soft_powerdown(soft_powerdown),
      .target_load_keying(target_load_keying),
      .cw_n_conductance_applied(cw_app), .mod_n_conductance_applied(mod_app),
      .carrier_tick(carrier_tick), .initiator_mode(initiator_mode), .pause_req(pause_req),
      .pause_active(pause_active), .subcarrier_en(subcarrier_en),
      .subcarrier_level(subcarrier_level), .tx_wait_base_done(tx_wait_base_done),
      .tx_start(tx_start), .miller_pause_length(pause_len), .demod_clock_from_field(demod_clk),
      .transmit_wait_extension(wait_ext), .field_detector_amp_on(amp_on),
      .receiver_gain_select(gain_sel), .receiver_gain_db(gain_db),
      .field_detector_sensitivity(sens)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // one apb transfer; an idle edge first keeps two transfers from colliding
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int k;
      k = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         $display("mismatch at %0t: no ready", $time);
         close_out();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h0000_0000, rd, err);
      `CHK(rd, {24'h000000, exp}, "read value")
      `CHK(err, 1'b0, "read error flag")
   endtask

   function automatic logic sig(input int s);
      return (s == 0) ? pause_active : (s == 1) ? subcarrier_level : tx_start;
   endfunction

   // counts falling edges while the chosen output keeps a level
   task automatic run_len(input int s, input logic v, output int c);
      c = 0;
      while (sig(s) === v && c < 400) begin
         @(negedge clk_sys);
         c++;
      end
      if (c >= 400) begin
         n_mismatch++;
         $display("mismatch at %0t: output stuck", $time);
         close_out();
      end
   endtask

   // drive the driver state and compare the applied nibbles at the falling edge after two rising edges
   task automatic cond(input logic d, p, k, input rfc_nib_t ecw, emod);
      @(posedge clk_sys);
      driver_on <= d;
      soft_powerdown <= p;
      target_load_keying <= k;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK(cw_app, ecw, "carrier conductance")
      `CHK(mod_app, emod, "modulation conductance")
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      // reset values of every register
      rd_chk(A_OFF, 8'h88);
      rd_chk(A_WID, 8'h26);
      rd_chk(A_PH, 8'h87);
      rd_chk(A_RF, 8'h48);
      rd_chk(A_ON, 8'h88);
      `CHK(gain_db, 6'h21, "reset gain")
      // upper bytes ignored, misaligned and unmapped places refused
      apb(1'b1, A_OFF, 32'hFFFF_FF35, rd, err);
      apb(1'b1, A_ON, 32'h0000_006A, rd, err);
      apb(1'b1, A_OFF + 8'h01, 32'h0000_00FF, rd, err);
      `CHK(err, 1'b1, "misaligned refused")
      apb(1'b0, 8'hA0, 32'h0000_0000, rd, err);
      `CHK(err, 1'b1, "unmapped refused")
      `CHK(rd, 32'h0000_0000, "unmapped data")
      rd_chk(A_OFF, 8'h35);
      rd_chk(A_ON, 8'h6A);
      // conductance selection, power-down forcing and load keying
      cond(1'b0, 1'b0, 1'b0, 4'h3, 4'h5);
      cond(1'b0, 1'b1, 1'b0, 4'hB, 4'hD);
      rd_chk(A_OFF, 8'h35);
      cond(1'b1, 1'b1, 1'b0, 4'hE, 4'hA);
      cond(1'b1, 1'b0, 1'b0, 4'h6, 4'hA);
      cond(1'b1, 1'b0, 1'b1, 4'h3, 4'h5);
      // every gain code with amplifier and sensitivity fields
      for (int g = 0; g < 8; g++) begin
         apb(1'b1, A_RF, {24'h000000, g[0], g[2:0], 4'(g + 3)}, rd, err);
         @(posedge clk_sys);
         @(negedge clk_sys);
         `CHK(gain_sel, g[2:0], "gain select")
         `CHK(gain_db, (g < 4) ? (g[0] ? 6'h17 : 6'h12) : 6'(33 + 5 * (g - 4)), "gain dB")
         `CHK(amp_on, g[0], "detector amplifier")
         `CHK(sens, 4'(g + 3), "detector sensitivity")
      end
      // demodulator clock source and wait extension, with the start pulse timing
      for (int e = 0; e < 3; e++) begin
         apb(1'b1, A_PH, {24'h000000, e[0], 7'(e * 3)}, rd, err);
         // the write lands on the edge that ends the task, so look once it has settled
         @(negedge clk_sys);
         `CHK(demod_clk, e[0], "demodulator clock source")
         `CHK(wait_ext, 7'(e * 3), "wait extension")
         @(posedge clk_sys);
         tx_wait_base_done <= 1'b1;
         @(posedge clk_sys);
         tx_wait_base_done <= 1'b0;
         @(negedge clk_sys);
         run_len(2, 1'b0, n);
         `CHK(n, e * 3 + 1, "start delay")
         run_len(2, 1'b1, n);
         `CHK(n, 1, "start pulse width")
      end
      // miller pause length, capped at half a bit, and refusal outside initiator mode
      for (int m = 0; m < 3; m++) begin
         apb(1'b1, A_WID, (m == 2) ? 32'h0000_00FF : 32'(m * 5), rd, err);
         @(negedge clk_sys);
         `CHK(pause_len, (m == 2) ? 8'hFF : 8'(m * 5), "width output")
         @(posedge clk_sys);
         initiator_mode <= 1'b1;
         pause_req <= 1'b1;
         @(posedge clk_sys);
         pause_req <= 1'b0;
         @(negedge clk_sys);
         run_len(0, 1'b1, n);
         `CHK(n, (m == 2) ? 64 : m * 5 + 1, "pause length")
      end
      @(posedge clk_sys);
      initiator_mode <= 1'b0;
      pause_req <= 1'b1;
      repeat (3) @(posedge clk_sys);
      pause_req <= 1'b0;
      @(negedge clk_sys);
      `CHK(pause_active, 1'b0, "pause refused")
      // ticks held off: a pause counts carrier ticks, never bare clocks
      @(posedge clk_sys);
      carrier_tick <= 1'b0;
      initiator_mode <= 1'b1;
      pause_req <= 1'b1;
      @(posedge clk_sys);
      pause_req <= 1'b0;
      repeat (70) @(posedge clk_sys);
      carrier_tick <= 1'b1;
      @(negedge clk_sys);
      `CHK(pause_active, 1'b1, "pause held without ticks")
      run_len(0, 1'b1, n);
      `CHK(n, 64, "pause length in ticks")
      // subcarrier duty cycle for two widths, whole phases measured
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, A_WID, s ? 32'h0000_000B : 32'h0000_0026, rd, err);
         @(posedge clk_sys);
         subcarrier_en <= 1'b1;
         @(negedge clk_sys);
         run_len(1, 1'b0, n);
         run_len(1, 1'b1, h);
         run_len(1, 1'b0, n);
         `CHK(n, s ? 4 : 7, "subcarrier low phase")
         `CHK(h, s ? 12 : 9, "subcarrier high phase")
         @(posedge clk_sys);
         subcarrier_en <= 1'b0;
      end
      close_out();
   end
endmodule
